// ==== clkr_decoder.sv ====
// clock ratio decoder top: reset capture, apb registers, local bus tick
`timescale 1ns/1ps
`default_nettype none
`include "clkr_defs.svh"

// Functional notes
// - four-bit field sets pll factor; 0=16, 1 reserved
// - csb ratio from multiplier and halving strap; clock modes do not affect it
// - halving strap doubles csb; codes 2..8 valid
// - local bus clock is lbiu divided by 2/4/8
// - lbiu clock one or two times csb
// - memory data moves at twice memory clock
// - host uses primary clock, agent uses pci clock
// - core ratio field sets core ratio; unlisted reserved
// - core oscillator equals core clock times divider
module clkr_decoder
  import clkr_pkg::*;
(
  input  wire logic                   CLOCK,
  input  wire logic                   RST_B,
  input  wire logic [`CLKR_WORD_W-1:0] CFG_WORD_LOW,
  input  wire logic                   CLKIN_DIV_STRAP,
  input  wire logic                   HOST_MODE_STRAP,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [7:0]             PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  output logic                        CFG_VALID,
  output logic                        REF_IS_PRIMARY,
  output logic      [5:0]             CSB_RATIO,
  output logic      [6:0]             LBIU_RATIO,
  output logic      [6:0]             MEM_CLK_RATIO,
  output logic      [7:0]             MEM_DATA_RATIO,
  output logic      [3:0]             CORE_RATIO_X2,
  output logic      [7:0]             CORE_VCO_RATIO_X2,
  output logic      [1:0]             CFG_RESERVED,
  output logic                        LB_TICK
);

  // ==================================================
  // declarations
  clkr_cfg_s   cfg_q;        // captured configuration
  clkr_cfg_s   cfg_d;        // next configuration
  logic        cap_done_q;   // capture taken
  logic        cap_done_d;   // next capture flag
  logic        valid_q;      // ratios settled
  logic        valid_d;      // next settled flag
  clkr_ratio_s dec;          // decoder output
  clkr_ratio_s ratio_q;      // registered ratios
  clkr_ratio_s ratio_d;      // next ratios
  logic [1:0]  lbdiv_q;      // local_bus_divider_field
  logic [1:0]  lbdiv_d;      // next divider field
  logic [4:0]  lb_period;    // tick period in clocks
  logic [3:0]  lb_cnt_q;     // tick counter
  logic [3:0]  lb_cnt_d;     // next tick counter
  logic        lb_tick_q;    // tick output flop
  logic        lb_tick_d;    // next tick
  logic        pready_q;     // apb ready flop
  logic        pready_d;     // next ready
  logic        pslverr_q;    // apb error flop
  logic        pslverr_d;    // next error
  logic [31:0] prdata_q;     // apb read data flop
  logic [31:0] prdata_d;     // next read data
  logic        hit;          // address decodes
  logic [31:0] rd_mux;       // selected read word

  // ==================================================
  // ratio decoder
  clkr_ratio_decode u_dec (
    .cfg   (cfg_q),
    .ratio (dec)
  );

  // ==================================================
  // reset-time capture, next values
  always_comb begin
    cfg_d      = cfg_q;
    cap_done_d = 1'b1;
    valid_d    = cap_done_q;
    ratio_d    = ratio_q;
    // first clock after reset release takes the straps once
    if (!cap_done_q) begin
      cfg_d.system_pll_mult_field     = CFG_WORD_LOW[`CLKR_MULT_LSB +: 4];
      cfg_d.local_bus_unit_clock_mode = CFG_WORD_LOW[`CLKR_LBMODE_BIT];
      cfg_d.memory_clock_mode         = CFG_WORD_LOW[`CLKR_MEMCK_BIT];
      cfg_d.core_field                = CFG_WORD_LOW[`CLKR_CORE_LSB +: 7];
      cfg_d.clkin_div                 = CLKIN_DIV_STRAP;
      cfg_d.host_mode                 = HOST_MODE_STRAP;
    end
    // ratios follow the captured word, then stand still
    if (cap_done_q) begin
      ratio_d = dec;
    end
  end

  // capture registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_q      <= '0;
      cap_done_q <= 1'b0;
      valid_q    <= 1'b0;
      ratio_q    <= '0;
    end else begin
      cfg_q      <= cfg_d;
      cap_done_q <= cap_done_d;
      valid_q    <= valid_d;
      ratio_q    <= ratio_d;
    end
  end

  // ==================================================
  // local bus tick divider, next values
  always_comb begin
    // divisor 2, 4 or 8 of lbiu; clock taken as lbiu at 2x csb
    unique case (lbdiv_q)
      `CLKR_LBDIV_2: lb_period = 5'h02;
      `CLKR_LBDIV_4: lb_period = 5'h04;
      default:       lb_period = 5'h08;
    endcase
    // lbiu at 1x csb runs half as fast
    if (!cfg_q.local_bus_unit_clock_mode) begin
      lb_period = {lb_period[3:0], 1'b0};
    end
    lb_tick_d = 1'b0;
    lb_cnt_d  = lb_cnt_q + 4'h1;
    if (!valid_q) begin
      lb_cnt_d = 4'h0;
    end else if ({1'b0, lb_cnt_q} >= lb_period - 5'h01) begin
      lb_cnt_d  = 4'h0;
      lb_tick_d = 1'b1;
    end
  end

  // tick registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lb_cnt_q  <= 4'h0;
      lb_tick_q <= 1'b0;
    end else begin
      lb_cnt_q  <= lb_cnt_d;
      lb_tick_q <= lb_tick_d;
    end
  end

  // ==================================================
  // apb slave, next values
  always_comb begin
    hit = (PADDR == `CLKR_ADDR_CFG) || (PADDR == `CLKR_ADDR_RATIO) ||
          (PADDR == `CLKR_ADDR_CORE) || (PADDR == `CLKR_ADDR_LBCTRL);
    // read words
    unique case (PADDR)
      `CLKR_ADDR_CFG:    rd_mux = {16'h0000, valid_q, cfg_q.host_mode, cfg_q.clkin_div,
                                   cfg_q.core_field, cfg_q.memory_clock_mode,
                                   cfg_q.local_bus_unit_clock_mode,
                                   cfg_q.system_pll_mult_field};
      `CLKR_ADDR_RATIO:  rd_mux = {ratio_q.mem_rate, 1'b0, ratio_q.mem_ratio,
                                   1'b0, ratio_q.lbiu_ratio, 2'h0, ratio_q.csb_ratio};
      `CLKR_ADDR_CORE:   rd_mux = {6'h00, ratio_q.core_rsv, ratio_q.mult_rsv,
                                   ratio_q.core_vco_x2, 4'h0, ratio_q.vco_div,
                                   4'h0, ratio_q.core_x2};
      `CLKR_ADDR_LBCTRL: rd_mux = {30'h0000_0000, lbdiv_q};
      default:           rd_mux = 32'h0000_0000;
    endcase
    // one wait state: ready in the second access cycle
    pready_d  = PSEL && PENABLE && !pready_q;
    pslverr_d = pready_d && !hit;
    prdata_d  = (pready_d && !PWRITE) ? rd_mux : 32'h0000_0000;
    // write lands on the completing edge only
    lbdiv_d = lbdiv_q;
    if (PSEL && PENABLE && pready_q && PWRITE && PADDR == `CLKR_ADDR_LBCTRL) begin
      lbdiv_d = PWDATA[1:0];
    end
  end

  // apb registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      lbdiv_q   <= `CLKR_LBCTRL_RST;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      lbdiv_q   <= lbdiv_d;
    end
  end

  // ==================================================
  // outputs, all from flops
  assign PRDATA            = prdata_q;
  assign PREADY            = pready_q;
  assign PSLVERR           = pslverr_q;
  assign CFG_VALID         = valid_q;
  assign REF_IS_PRIMARY    = cfg_q.host_mode;
  assign CSB_RATIO         = ratio_q.csb_ratio;
  assign LBIU_RATIO        = ratio_q.lbiu_ratio;
  assign MEM_CLK_RATIO     = ratio_q.mem_ratio;
  assign MEM_DATA_RATIO    = ratio_q.mem_rate;
  assign CORE_RATIO_X2     = ratio_q.core_x2;
  assign CORE_VCO_RATIO_X2 = ratio_q.core_vco_x2;
  assign CFG_RESERVED      = {ratio_q.core_rsv, ratio_q.mult_rsv};
  assign LB_TICK           = lb_tick_q;

  // ==================================================
  // assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // code 0 gives sixteen
  property p_mult16;
    valid_q && cfg_q.system_pll_mult_field == 4'h0 |-> ratio_q.sys_mult == 5'h10;
  endproperty
  a_mult16: assert property (p_mult16) else $error("code 0 not x16");

  // code 1 flagged reserved
  property p_mult_rsv;
    valid_q && cfg_q.system_pll_mult_field == 4'h1 |-> CFG_RESERVED[0];
  endproperty
  a_mult_rsv: assert property (p_mult_rsv) else $error("code 1 not reserved");

  // csb ratio without the strap equals the factor
  property p_csb_plain;
    valid_q && !cfg_q.clkin_div && cfg_q.system_pll_mult_field > 4'h1
      |-> CSB_RATIO == {2'h0, cfg_q.system_pll_mult_field};
  endproperty
  a_csb_plain: assert property (p_csb_plain) else $error("csb ratio wrong");

  // strap doubles the ratio
  property p_half;
    valid_q && cfg_q.clkin_div && cfg_q.system_pll_mult_field inside {[4'h2:4'h8]}
      |-> CSB_RATIO == {1'b0, cfg_q.system_pll_mult_field, 1'b0} && !CFG_RESERVED[0];
  endproperty
  a_half: assert property (p_half) else $error("halving strap ratio wrong");

  // ticks two apart while the /2 period stands; a divider write
  // right after a tick re-times the count, so the period must
  // still be 2 in the cycle that decides the next tick
  property p_lb_tick;
    LB_TICK && lb_period == 5'h02 ##1 lb_period == 5'h02 |-> !LB_TICK ##1 LB_TICK;
  endproperty
  a_lb_tick: assert property (p_lb_tick) else $error("local bus tick spacing");

  // lbiu one or two times csb
  property p_lbiu;
    valid_q |-> LBIU_RATIO == (cfg_q.local_bus_unit_clock_mode ? {CSB_RATIO, 1'b0}
                                                                : {1'b0, CSB_RATIO});
  endproperty
  a_lbiu: assert property (p_lbiu) else $error("lbiu ratio wrong");

  // data rate twice memory clock
  property p_mem;
    valid_q |-> MEM_DATA_RATIO == {MEM_CLK_RATIO, 1'b0};
  endproperty
  a_mem: assert property (p_mem) else $error("memory data rate wrong");

  // reference follows host strap as captured
  property p_ref;
    $rose(cap_done_q) |-> REF_IS_PRIMARY == $past(HOST_MODE_STRAP);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  // unlisted core codes flagged
  property p_core_rsv;
    valid_q && cfg_q.core_field[4:0] > 5'h08 |-> CFG_RESERVED[1];
  endproperty
  a_core_rsv: assert property (p_core_rsv) else $error("core code not reserved");

  // low core codes flagged too
  property p_core_lo;
    valid_q && cfg_q.core_field[4:0] < 5'h02 |-> CFG_RESERVED[1];
  endproperty
  a_core_lo: assert property (p_core_lo) else $error("low core code not reserved");

  // oscillator ratio is core times divider
  property p_vco;
    valid_q |-> CORE_VCO_RATIO_X2 == 8'({4'h0, CORE_RATIO_X2} * {4'h0, ratio_q.vco_div});
  endproperty
  a_vco: assert property (p_vco) else $error("oscillator ratio wrong");

  // ratios hold once settled
  property p_hold;
    valid_q && $past(valid_q) |-> $stable(ratio_q) && $stable(cfg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("ratios changed after capture");

  // settled flag rises one cycle after the capture
  property p_valid;
    $rose(cap_done_q) |-> !valid_q ##1 valid_q;
  endproperty
  a_valid: assert property (p_valid) else $error("settled flag timing wrong");

  // ready stands one cycle only, so no transfer completes twice
  property p_ready_pulse;
    PREADY |-> ##1 !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  // main scenarios
  c_half: cover property (valid_q && cfg_q.clkin_div);
  c_core: cover property (valid_q && CFG_RESERVED[1]);
  c_tick: cover property (LB_TICK && lbdiv_q == 2'h2);
  c_read: cover property (PREADY && !PWRITE && !PSLVERR);
  c_err:  cover property (PREADY && PSLVERR);

endmodule
`default_nettype wire

// ==== clkr_defs.svh ====
// offsets, field positions, reset values and codes for the clock ratio decoder
`ifndef CLKR_DEFS_SVH
`define CLKR_DEFS_SVH

// ==================================================
// register byte offsets
`define CLKR_ADDR_CFG      8'h00
`define CLKR_ADDR_RATIO    8'h04
`define CLKR_ADDR_CORE     8'h08
`define CLKR_ADDR_LBCTRL   8'h0C

// ==================================================
// reset config word low layout
`define CLKR_WORD_W        13
`define CLKR_MULT_LSB      0
`define CLKR_LBMODE_BIT    4
`define CLKR_MEMCK_BIT     5
`define CLKR_CORE_LSB      6

// ==================================================
// local bus control reset value and divider codes
`define CLKR_LBCTRL_RST    2'h0
`define CLKR_LBDIV_2       2'h0
`define CLKR_LBDIV_4       2'h1
`define CLKR_LBDIV_8       2'h2

// ==================================================
// multiplication and core ratio codes
`define CLKR_MULT_X16      4'h0
`define CLKR_MULT_RSV      4'h1
`define CLKR_MULT_HALF_MIN 4'h2
`define CLKR_MULT_HALF_MAX 4'h8
`define CLKR_CORE_X2_MIN   5'h02
`define CLKR_CORE_X2_MAX   5'h08

`endif

// ==== clkr_pkg.sv ====
// types shared by the clock ratio decoder files
`default_nettype none
package clkr_pkg;

  // ==================================================
  // captured reset-time configuration
  typedef struct packed {
    logic [3:0] system_pll_mult_field;      // pll factor code
    logic       local_bus_unit_clock_mode;  // lbiu at 2x csb
    logic       memory_clock_mode;          // memory clock at 2x csb
    logic [6:0] core_field;  // core_ratio_field
    logic       clkin_div;   // input halving strap
    logic       host_mode;   // host or agent strap
  } clkr_cfg_s;

  // ==================================================
  // decoded ratios
  typedef struct packed {
    logic [4:0] sys_mult;    // pll multiplication factor
    logic [5:0] csb_ratio;   // csb : input clock
    logic [6:0] lbiu_ratio;  // lbiu : input clock
    logic [6:0] mem_ratio;   // memory bus clock : input clock
    logic [7:0] mem_rate;    // memory data rate : input clock
    logic [3:0] core_x2;     // twice core : csb
    logic [3:0] vco_div;     // core oscillator divider
    logic [7:0] core_vco_x2; // twice core oscillator : csb
    logic       mult_rsv;    // reserved multiplication code
    logic       core_rsv;    // reserved core code
  } clkr_ratio_s;

endpackage
`default_nettype wire

// ==== clkr_ratio_decode.sv ====
// combinational decode of captured configuration into clock ratios
`timescale 1ns/1ps
`default_nettype none
`include "clkr_defs.svh"

module clkr_ratio_decode
  import clkr_pkg::*;
(
  input  wire clkr_cfg_s   cfg,
  output var  clkr_ratio_s ratio
);

  // ==================================================
  // ratio decode
  always_comb begin
    ratio = '0;
    // multiplication factor, 0 means 16, 1 reserved
    if (cfg.system_pll_mult_field == `CLKR_MULT_X16) begin
      ratio.sys_mult = 5'h10;
    end else begin
      ratio.sys_mult = {1'b0, cfg.system_pll_mult_field};
    end
    ratio.mult_rsv = (cfg.system_pll_mult_field == `CLKR_MULT_RSV);
    // halving strap doubles csb and limits the codes
    if (cfg.clkin_div) begin
      ratio.csb_ratio = {ratio.sys_mult, 1'b0};
      if (cfg.system_pll_mult_field < `CLKR_MULT_HALF_MIN ||
          cfg.system_pll_mult_field > `CLKR_MULT_HALF_MAX) begin
        ratio.mult_rsv = 1'b1;
      end
    end else begin
      ratio.csb_ratio = {1'b0, ratio.sys_mult};
    end
    // lbiu is one or two times csb
    ratio.lbiu_ratio = cfg.local_bus_unit_clock_mode ? {ratio.csb_ratio, 1'b0}
                                                     : {1'b0, ratio.csb_ratio};
    // memory clock one or two times csb, data on both edges
    ratio.mem_ratio = cfg.memory_clock_mode ? {ratio.csb_ratio, 1'b0}
                                            : {1'b0, ratio.csb_ratio};
    ratio.mem_rate = {ratio.mem_ratio, 1'b0};
    // core ratio in half steps, unlisted codes reserved
    ratio.core_x2 = cfg.core_field[3:0];
    if (cfg.core_field[4:0] < `CLKR_CORE_X2_MIN || cfg.core_field[4:0] > `CLKR_CORE_X2_MAX) begin
      ratio.core_rsv = 1'b1;
    end
    // oscillator divider 2, 4 or 8; 11 reserved
    unique case (cfg.core_field[6:5])
      2'h0: ratio.vco_div = 4'h2;
      2'h1: ratio.vco_div = 4'h4;
      2'h2: ratio.vco_div = 4'h8;
      default: begin
        ratio.vco_div  = 4'h8;
        ratio.core_rsv = 1'b1;
      end
    endcase
    ratio.core_vco_x2 = 8'({4'h0, ratio.core_x2} * {4'h0, ratio.vco_div});
  end

endmodule
`default_nettype wire

// ==== clkr_cfg_model.sv ====
// reset configuration source model: drives word and straps around reset
`timescale 1ns/1ps
`default_nettype none

module clkr_cfg_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [12:0] word_req,
  input  wire logic [1:0]  strap_req,
  output logic      [12:0] word,
  output logic             clkin_div,
  output logic             host_mode
);
  logic [1:0] age_q; // edges seen since reset release
  logic [1:0] age_d; // next edge count

  // ==================================================
  // age counter: stops two edges after release
  always_comb begin
    age_d = age_q;
    if (age_q != 2'h2) begin
      age_d = age_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age_q <= 2'h0;
    end else begin
      age_q <= age_d;
    end
  end

  // ==================================================
  // pins: setting held past the capture edge, then inverted so a
  // late resample would show up in the ratios
  always_comb begin
    if (age_q != 2'h2) begin
      word      = word_req;
      clkin_div = strap_req[0];
      host_mode = strap_req[1];
    end else begin
      word      = ~word_req;
      clkin_div = ~strap_req[0];
      host_mode = ~strap_req[1];
    end
  end
endmodule
`default_nettype wire

// ==== clkr_decoder_test.sv ====
// self-checking testbench for the clock ratio decoder
`timescale 1ns/1ps
`default_nettype none
`include "clkr_defs.svh"

module clkr_decoder_test
  import clkr_pkg::*;
;
  logic        clock, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cfg_valid, ref_pri, lb_tick, err;
  logic [5:0]  csb;
  logic [6:0]  lbiu, memclk;
  logic [7:0]  memdata, vco;
  logic [3:0]  core;
  logic [1:0]  rsv, strap_req;
  logic [12:0] word_req, word;
  logic        div_pin, host_pin;
  int          fail_count = 0;
  int          checks = 0;
  int          gap;

  clkr_cfg_model i_clkr_cfg_model (.clk(clock), .rst_b(rst_b), .word_req(word_req),
    .strap_req(strap_req), .word(word), .clkin_div(div_pin), .host_mode(host_pin));

  clkr_decoder i_clkr_decoder (.CLOCK(clock), .RST_B(rst_b), .CFG_WORD_LOW(word),
    .CLKIN_DIV_STRAP(div_pin), .HOST_MODE_STRAP(host_pin), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CFG_VALID(cfg_valid),
    .REF_IS_PRIMARY(ref_pri), .CSB_RATIO(csb), .LBIU_RATIO(lbiu),
    .MEM_CLK_RATIO(memclk), .MEM_DATA_RATIO(memdata), .CORE_RATIO_X2(core),
    .CORE_VCO_RATIO_X2(vco), .CFG_RESERVED(rsv), .LB_TICK(lb_tick));

  // ==================================================
  // clock and time-zero values
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ==================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reset with a given setting, return once ratios are settled
  task automatic boot(input logic [12:0] w, input logic div, input logic host);
    int n;
    @(posedge clock);
    word_req  <= w;
    strap_req <= {host, div};
    rst_b     <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    n = 0;
    // outputs read on the falling edge, clear of the launching edge
    do begin
      @(negedge clock);
      n++;
    end while (cfg_valid !== 1'b1 && n < 20);
    chk(cfg_valid, 1'b1);
    @(negedge clock);
  endtask

  // one apb transfer, waits for pready with no bound of its own
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles between local bus ticks, after the divider has settled
  task automatic tick_gap;
    repeat (3) begin
      gap = 0;
      do begin
        @(negedge clock);
        gap++;
      end while (lb_tick !== 1'b1 && gap < 100);
    end
  endtask

  // ==================================================
  // scenarios
  task automatic t_pll;
    for (int c = 0; c < 16; c++) begin
      boot({7'h02, 2'b00, 4'(c)}, 1'b0, 1'b1);
      if (c != 1) chk(csb, (c == 0) ? 16 : c);
      chk(rsv[0], c == 1);
    end
  endtask

  task automatic t_half;
    for (int c = 2; c < 10; c++) begin
      boot({7'h02, 2'b00, 4'(c)}, 1'b1, 1'b1);
      if (c <= 8) chk(csb, 2 * c);
      chk(rsv[0], c > 8);
    end
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      boot({7'h02, 2'(m), 4'h4}, 1'b0, m[0]);
      chk(csb, 4);
      chk(lbiu, 4 * (1 + m[0]));
      chk(memclk, 4 * (1 + m[1]));
      chk(memdata, 8 * (1 + m[1]));
      chk(ref_pri, m[0]);
    end
  endtask

  task automatic t_core;
    for (int x = 1; x < 10; x++) begin
      for (int d = 0; d < 4; d++) begin
        boot({2'(d), 5'(x), 2'b00, 4'h2}, 1'b0, 1'b1);
        chk(core, x);
        if (d < 3) chk(vco, x * (2 << d));
        chk(rsv[1], x < 2 || x > 8 || d == 3);
      end
    end
  endtask

  task automatic t_hold;
    boot({7'h02, 2'b00, 4'h5}, 1'b0, 1'b1);
    repeat (20) @(negedge clock);
    chk(csb, 5);
    chk(ref_pri, 1'b1);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    chk(err, 1'b0);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_C085);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0A05_0505);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic t_lbdiv;
    int exp_gap [4] = '{2, 4, 8, 8};
    boot({7'h02, 2'b01, 4'h4}, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h0C, 32'(k));
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(rd, k);
      tick_gap();
      chk(gap, exp_gap[k]);
    end
    boot({7'h02, 2'b00, 4'h4}, 1'b0, 1'b1);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    tick_gap();
    chk(gap, 8);
  endtask

  // ==================================================
  // main sequence and watchdog
  initial begin
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    word_req  = 13'h0000;
    strap_req = 2'b00;
    t_pll();
    t_half();
    t_modes();
    t_core();
    t_hold();
    t_lbdiv();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
